// >>> hw/lmref_pkg.sv
// package: constants and types of the local memory reference sequencer
// Functional notes
// - write opcode strobes enter-address with write request
// - read opcode strobes enter-address, write request low
// - operand selected by pointer captured into address
// - operand request waits while fetch request pending
// - acknowledge only when local memory is free
// - gate selects address register, drives accumulator out
// - gate releases operands, accumulator too on write
// - write unit captures accumulator, makes check bits
// - operand request dropped on acknowledge
// - address crosses to address unit in two periods
// - low nibbles, high nibbles, then full address
// - write data and enables after request clears
// - acknowledge retires the pending write instruction
// - read data checked then sent to accumulator
// - read retires and loads accumulator or index
// - fetch requested while load minus read below twelve
// - fetch acknowledge drops request only at twelve
// - fetched parcel checked then given to stack
// - fetch address crosses in two periods too
// - fetch acknowledge sends stack address and write
// - bypass with invalid parcel loads it directly
// - processor and channel requests alternate priority
// - bypass when pointers equal and parcel invalid
package lmref_pkg;
	localparam int ADDR_W = 16;
	localparam int PARCEL_W = 16;
	localparam int HAM_W = 5;
	localparam int CHECK_W = 6;
	localparam int WORD_W = 22;
	localparam int OPC_W = 7;
	localparam int STACK_DEPTH = 32;
	localparam int FETCH_LOW_WATER = 12;
	localparam int IO_SLOT_CYCLES = 3;
	localparam logic [OPC_W-1:0] OPC_READ = 7'h18; // octal 030
	localparam logic [OPC_W-1:0] OPC_WRITE = 7'h1c; // octal 034
	// register port: word offsets on a 4-bit byte address
	localparam int REG_AW = 4;
	localparam logic [REG_AW-1:0] REG_CTRL = 4'h0;
	localparam logic [REG_AW-1:0] REG_STATUS = 4'h4;
	localparam logic [REG_AW-1:0] REG_SEC_CNT = 4'h8;
	localparam logic [REG_AW-1:0] REG_DED_CNT = 4'hc;
	localparam int CTRL_FETCH_EN_BIT = 0;
	localparam int CTRL_CLR_BIT = 1;
	localparam logic CTRL_FETCH_EN_RESET = 1'b1;
	localparam int ST_FETCH_REQ_BIT = 0;
	localparam int ST_MEM_REQ_BIT = 1;
	localparam int ST_NIP_VALID_BIT = 2;
	localparam int ST_SEC_BIT = 3;
	localparam int ST_DED_BIT = 4;
	localparam int ST_BUSY_BIT = 5;
	// one command to the storage arrays
	typedef struct packed {
		logic rd;
		logic [1:0] we;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] word;
	} arr_cmd_t;
	typedef enum logic [5:0] {
		S_IDLE = 6'h01,
		S_ADDR1 = 6'h02,
		S_ADDR2 = 6'h04,
		S_ADDR3 = 6'h08,
		S_WAIT = 6'h10,
		S_IO = 6'h20
	} seq_state_t;
	// codeword position of data bit k, skipping power-of-two slots
	function automatic logic [HAM_W-1:0] data_pos(input int k);
		int n;
		logic [HAM_W-1:0] r;
		n = 0;
		r = '0;
		for (int p = 3; p < 22; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (n == k) r = HAM_W'(p);
				n++;
			end
		end
		return r;
	endfunction
endpackage

// >>> hw/secded_encode.sv
// module: check bit generator for one 16-bit parcel
`timescale 1ns/1ns
`default_nettype none
module secded_encode (
	input wire logic [lmref_pkg::PARCEL_W-1:0] data,
	output logic [lmref_pkg::CHECK_W-1:0] check
);
	import lmref_pkg::*;
	logic [HAM_W-1:0] ham;
	logic [HAM_W-1:0] p;
	// hamming bits, then overall parity so double errors show
	always_comb begin
		ham = '0;
		p = '0;
		for (int k = 0; k < PARCEL_W; k++) begin
			p = data_pos(k);
			for (int i = 0; i < HAM_W; i++) begin
				if (p[i]) ham[i] = ham[i] ^ data[k];
			end
		end
		check = {^{data, ham}, ham};
	end
endmodule // secded_encode
`default_nettype wire

// >>> hw/secded_check.sv
// module: error check and single-bit correction of a stored word
`timescale 1ns/1ns
`default_nettype none
module secded_check (
	input wire logic [lmref_pkg::WORD_W-1:0] word,
	output logic [lmref_pkg::PARCEL_W-1:0] data,
	output logic sec,
	output logic ded
);
	import lmref_pkg::*;
	logic [HAM_W-1:0] syn;
	logic [HAM_W-1:0] p;
	logic par;
	// a check-bit hit leaves the data untouched but still counts
	always_comb begin
		syn = word[PARCEL_W +: HAM_W];
		p = '0;
		for (int k = 0; k < PARCEL_W; k++) begin
			p = data_pos(k);
			for (int i = 0; i < HAM_W; i++) begin
				if (p[i]) syn[i] = syn[i] ^ word[k];
			end
		end
		par = ^word;
		sec = par;
		ded = !par && (syn != '0);
		data = word[PARCEL_W-1:0];
		for (int k = 0; k < PARCEL_W; k++) begin
			if (par && syn == data_pos(k)) data[k] = ~data[k];
		end
	end
endmodule // secded_check
`default_nettype wire

// >>> hw/lmref_sequencer.sv
// module: processor local memory reference sequencer and arbiter
`timescale 1ns/1ns
`default_nettype none
module lmref_sequencer #(
	parameter int STACK_DEPTH = lmref_pkg::STACK_DEPTH,
	parameter int LOW_WATER = lmref_pkg::FETCH_LOW_WATER
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic [lmref_pkg::OPC_W-1:0] instr_opcode,
	input wire logic steer_to_index,
	input wire logic [lmref_pkg::ADDR_W-1:0] operand_data,
	input wire logic [lmref_pkg::PARCEL_W-1:0] accumulator_data,
	input wire logic branch_load,
	input wire logic [lmref_pkg::ADDR_W-1:0] branch_addr,
	input wire logic nip_take,
	input wire logic io_req,
	input wire logic [lmref_pkg::WORD_W-1:0] arr_rdata,
	input wire logic arr_rvalid,
	input wire logic [lmref_pkg::REG_AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic ref_busy_q,
	output logic release_acc_q,
	output logic release_opnd_q,
	output logic retire_write_q,
	output logic retire_read_q,
	output logic acc_load_q,
	output logic load_index_q,
	output logic [lmref_pkg::PARCEL_W-1:0] acc_data_q,
	output logic [lmref_pkg::PARCEL_W-1:0] nip_q,
	output logic nip_valid_q,
	output logic io_ack_q,
	output lmref_pkg::arr_cmd_t arr_cmd_q,
	output logic [31:0] reg_rdata_q
);
	import lmref_pkg::*;
	localparam int SAW = $clog2(STACK_DEPTH);

	// refuse a stack that cannot hold the fetch window plus one
	if (STACK_DEPTH < 4 || LOW_WATER < 1 || LOW_WATER > STACK_DEPTH - 2
		|| (1 << SAW) != STACK_DEPTH) begin : g_bad_params
		$error("lmref_sequencer: unusable stack depth or low water");
	end

	seq_state_t state_q;
	logic enter_memory_address_strobe_q, wr_ref_q, op_pend_q, op_wr_q, steer_q;
	logic mem_req_q, write_req_q, gate_q, fetch_req_q;
	logic ack_q, ack_op_q, prio_io_q, kill_q, bypass_q;
	logic [ADDR_W-1:0] ma_q, fetch_ptr_q, src_q, addr_lat_q;
	logic [7:0] xfer_q;
	logic [PARCEL_W-1:0] wdata_q;
	logic [CHECK_W-1:0] wcheck_q;
	logic [SAW-1:0] load_ptr_q, rd_ptr_q, done_ptr_q, stack_addr_q;
	logic [PARCEL_W-1:0] stack_mem [STACK_DEPTH];
	logic [1:0] io_cnt_q;
	logic fetch_en_q, sec_seen_q, ded_seen_q;
	logic [15:0] sec_cnt_q, ded_cnt_q;

	// decode: only the two memory opcodes start a reference
	wire is_wr = instr_opcode == OPC_WRITE;
	wire is_rd = instr_opcode == OPC_READ;
	wire take_instr = instr_valid && (is_wr || is_rd) && !ref_busy_q;
	wire retire_any = retire_write_q || retire_read_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enter_memory_address_strobe_q <= 1'b0;
			wr_ref_q <= 1'b0;
			ref_busy_q <= 1'b0;
		end else begin
			enter_memory_address_strobe_q <= take_instr;
			wr_ref_q <= take_instr && is_wr;
			ref_busy_q <= take_instr || (ref_busy_q && !retire_any);
		end
	end

	// sequencer: an operand reference defers to a pending fetch
	wire issue = op_pend_q && !fetch_req_q && !mem_req_q;
	wire op_ack = ack_q && ack_op_q;
	wire fetch_ack = ack_q && !ack_op_q;
	wire [SAW-1:0] occupancy = load_ptr_q - rd_ptr_q;
	wire room = occupancy < SAW'(LOW_WATER);
	wire mem_free = state_q == S_IDLE;
	wire cpu_line = mem_req_q || fetch_req_q;
	wire grant_cpu = mem_free && cpu_line && (!io_req || !prio_io_q);
	wire grant_io = mem_free && io_req && (!cpu_line || prio_io_q);
	wire bypass_now = (load_ptr_q == rd_ptr_q) && !nip_valid_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			op_pend_q <= 1'b0;
			op_wr_q <= 1'b0;
			steer_q <= 1'b0;
			mem_req_q <= 1'b0;
			write_req_q <= 1'b0;
			gate_q <= 1'b0;
		end else begin
			op_pend_q <= enter_memory_address_strobe_q || (op_pend_q && !issue);
			if (enter_memory_address_strobe_q) op_wr_q <= wr_ref_q;
			if (take_instr) steer_q <= steer_to_index;
			mem_req_q <= issue || (mem_req_q && !op_ack);
			write_req_q <= (issue && op_wr_q) || (write_req_q && !op_ack);
			gate_q <= issue;
		end
	end

	// fetch request stays up while the window is short of full
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fetch_req_q <= 1'b0;
		end else begin
			fetch_req_q <= fetch_en_q && !branch_load
				&& (room || (fetch_req_q && !fetch_ack));
		end
	end

	// arbiter: whoever was served last yields to the other
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			ack_op_q <= 1'b0;
			io_ack_q <= 1'b0;
			prio_io_q <= 1'b0;
		end else begin
			ack_q <= grant_cpu;
			if (grant_cpu) ack_op_q <= mem_req_q; // kind must last until data returns
			io_ack_q <= grant_io;
			if (grant_cpu) prio_io_q <= 1'b1;
			else if (grant_io) prio_io_q <= 1'b0;
		end
	end

	// register slices: capture address, steer it out in nibble pairs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ma_q <= '0;
			src_q <= '0;
			xfer_q <= '0;
		end else begin
			if (enter_memory_address_strobe_q) ma_q <= operand_data;
			if (grant_cpu) begin
				src_q <= mem_req_q ? ma_q : fetch_ptr_q;
				xfer_q <= mem_req_q ? {ma_q[11:8], ma_q[3:0]}
					: {fetch_ptr_q[11:8], fetch_ptr_q[3:0]};
			end else if (state_q == S_ADDR1) begin
				xfer_q <= {src_q[15:12], src_q[7:4]};
			end
		end
	end

	// write data unit: the accumulator is driven here on gate
	logic [CHECK_W-1:0] enc_check;
	secded_encode u_encode (
		.data(accumulator_data),
		.check(enc_check)
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wdata_q <= '0;
			wcheck_q <= '0;
			release_opnd_q <= 1'b0;
			release_acc_q <= 1'b0;
			retire_write_q <= 1'b0;
		end else begin
			if (gate_q && write_req_q) begin
				wdata_q <= accumulator_data;
				wcheck_q <= enc_check;
			end
			release_opnd_q <= gate_q;
			release_acc_q <= gate_q && write_req_q;
			retire_write_q <= op_ack && op_wr_q;
		end
	end

	// read side: checked array word, used by reads and fetches
	logic [PARCEL_W-1:0] chk_data;
	logic chk_sec, chk_ded;
	secded_check u_check (
		.word(arr_rdata),
		.data(chk_data),
		.sec(chk_sec),
		.ded(chk_ded)
	);
	wire rd_done = state_q == S_WAIT && arr_rvalid;
	wire stack_wr = rd_done && !ack_op_q && !kill_q;
	wire avail = rd_ptr_q != done_ptr_q;
	wire bypass_fire = stack_wr && bypass_q && !nip_valid_q && !avail;
	wire refill = avail && (!nip_valid_q || nip_take);

	// sequence: two nibble periods, present, then write or wait
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE;
			addr_lat_q <= '0;
			arr_cmd_q <= '0;
			io_cnt_q <= '0;
		end else begin
			arr_cmd_q.rd <= 1'b0;
			arr_cmd_q.we <= 2'b00;
			case (state_q)
				S_IDLE: begin
					if (grant_cpu) state_q <= S_ADDR1;
					else if (grant_io) begin
						state_q <= S_IO;
						io_cnt_q <= 2'(IO_SLOT_CYCLES - 1);
					end
				end
				S_ADDR1: begin
					addr_lat_q[3:0] <= xfer_q[3:0];
					addr_lat_q[11:8] <= xfer_q[7:4];
					state_q <= S_ADDR2;
				end
				S_ADDR2: begin
					addr_lat_q[7:4] <= xfer_q[3:0];
					addr_lat_q[15:12] <= xfer_q[7:4];
					state_q <= S_ADDR3;
				end
				S_ADDR3: begin
					arr_cmd_q.addr <= addr_lat_q;
					if (ack_op_q && op_wr_q) begin
						arr_cmd_q.word <= {wcheck_q, wdata_q};
						arr_cmd_q.we <= 2'b11;
						state_q <= S_IDLE;
					end else begin
						arr_cmd_q.rd <= 1'b1;
						state_q <= S_WAIT;
					end
				end
				S_WAIT: begin
					if (arr_rvalid) state_q <= S_IDLE;
				end
				S_IO: begin
					if (io_cnt_q == 2'h0) state_q <= S_IDLE;
					else io_cnt_q <= io_cnt_q - 2'h1;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// read return: corrected parcel to accumulator or index
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_load_q <= 1'b0;
			load_index_q <= 1'b0;
			retire_read_q <= 1'b0;
			acc_data_q <= '0;
		end else begin
			acc_load_q <= rd_done && ack_op_q;
			retire_read_q <= rd_done && ack_op_q;
			if (rd_done && ack_op_q) begin
				acc_data_q <= chk_data;
				load_index_q <= steer_q;
			end
		end
	end

	// instruction stack: slot reserved at acknowledge, filled later
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fetch_ptr_q <= '0;
			load_ptr_q <= '0;
			done_ptr_q <= '0;
			rd_ptr_q <= '0;
			stack_addr_q <= '0;
			bypass_q <= 1'b0;
			kill_q <= 1'b0;
			nip_q <= '0;
			nip_valid_q <= 1'b0;
		end else if (branch_load) begin
			fetch_ptr_q <= branch_addr;
			load_ptr_q <= '0;
			done_ptr_q <= '0;
			rd_ptr_q <= '0;
			kill_q <= 1'b1; // a fetch in flight is now stale
			nip_valid_q <= 1'b0;
		end else begin
			if (grant_cpu) kill_q <= 1'b0;
			if (fetch_ack && !kill_q) begin
				stack_addr_q <= load_ptr_q;
				load_ptr_q <= load_ptr_q + 1'b1;
				fetch_ptr_q <= fetch_ptr_q + 1'b1;
				bypass_q <= bypass_now;
			end
			if (stack_wr) done_ptr_q <= done_ptr_q + 1'b1;
			if (bypass_fire) begin
				nip_q <= chk_data;
				nip_valid_q <= 1'b1;
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end else if (refill) begin
				nip_q <= stack_mem[rd_ptr_q];
				nip_valid_q <= 1'b1;
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end else if (nip_take) begin
				nip_valid_q <= 1'b0;
			end
		end
	end

	// stack array has no reset; the pointers say what is valid
	always_ff @(posedge clock) begin
		if (stack_wr) stack_mem[stack_addr_q] <= chk_data;
	end

	// software port: fetch enable, sticky error flags, counters
	wire ctrl_wr = reg_write && reg_addr == REG_CTRL;
	wire clr = ctrl_wr && reg_wdata[CTRL_CLR_BIT];
	wire sec_ev = rd_done && chk_sec;
	wire ded_ev = rd_done && chk_ded;
	wire [31:0] status_word = {26'h0, state_q != S_IDLE, ded_seen_q,
		sec_seen_q, nip_valid_q, mem_req_q, fetch_req_q};
	logic [31:0] rd_mux;
	always_comb begin
		if (reg_addr == REG_CTRL) rd_mux = {31'h0, fetch_en_q};
		else if (reg_addr == REG_STATUS) rd_mux = status_word;
		else if (reg_addr == REG_SEC_CNT) rd_mux = {16'h0, sec_cnt_q};
		else if (reg_addr == REG_DED_CNT) rd_mux = {16'h0, ded_cnt_q};
		else rd_mux = 32'h0;
	end

	// an error in the clearing cycle survives the clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fetch_en_q <= CTRL_FETCH_EN_RESET;
			sec_seen_q <= 1'b0;
			ded_seen_q <= 1'b0;
			sec_cnt_q <= '0;
			ded_cnt_q <= '0;
			reg_rdata_q <= '0;
		end else begin
			if (ctrl_wr) fetch_en_q <= reg_wdata[CTRL_FETCH_EN_BIT];
			sec_seen_q <= sec_ev || (sec_seen_q && !clr);
			ded_seen_q <= ded_ev || (ded_seen_q && !clr);
			if (sec_ev) sec_cnt_q <= (clr ? 16'h0 : sec_cnt_q) + 16'h1;
			else if (clr) sec_cnt_q <= '0;
			if (ded_ev) ded_cnt_q <= (clr ? 16'h0 : ded_cnt_q) + 16'h1;
			else if (clr) ded_cnt_q <= '0;
			reg_rdata_q <= reg_read ? rd_mux : 32'h0;
		end
	end

	// checks kept beside the logic they watch
	a_gate_after_fetch: assert property (
		@(posedge clock) disable iff (!rst_n)
		$rose(mem_req_q) |-> gate_q && !$past(fetch_req_q))
		else $error("operand request raised over a pending fetch");

	a_req_held: assert property (
		@(posedge clock) disable iff (!rst_n)
		mem_req_q && !op_ack |=> mem_req_q)
		else $error("operand request dropped before acknowledge");

	a_ack_drops_req: assert property (
		@(posedge clock) disable iff (!rst_n)
		op_ack |=> !mem_req_q && !write_req_q)
		else $error("operand request not dropped after acknowledge");

	a_addr_third: assert property (
		@(posedge clock) disable iff (!rst_n)
		ack_q ##2 1'b1 |=> (arr_cmd_q.rd || arr_cmd_q.we != 2'b00)
			&& arr_cmd_q.addr == $past(src_q, 2))
		else $error("address not presented in the third period");

	a_we_after_clear: assert property (
		@(posedge clock) disable iff (!rst_n)
		arr_cmd_q.we != 2'b00 |-> !write_req_q
			&& arr_cmd_q.word[PARCEL_W-1:0] == wdata_q)
		else $error("write enables while write request still up");

	a_retire_write: assert property (
		@(posedge clock) disable iff (!rst_n)
		op_ack && op_wr_q |=> retire_write_q ##1 !retire_write_q)
		else $error("write not retired once on acknowledge");

	a_release_kind: assert property (
		@(posedge clock) disable iff (!rst_n)
		gate_q |=> release_opnd_q && release_acc_q == $past(write_req_q))
		else $error("wrong registers released on gate");

	a_fetch_low: assert property (
		@(posedge clock) disable iff (!rst_n)
		room && fetch_en_q && !branch_load |=> fetch_req_q)
		else $error("fetch not requested with short window");

	a_prio_swap: assert property (
		@(posedge clock) disable iff (!rst_n)
		grant_io |=> !prio_io_q ##[1:8] !io_req || !cpu_line || !grant_io)
		else $error("channel served twice over a waiting processor");

	a_read_return: assert property (
		@(posedge clock) disable iff (!rst_n)
		rd_done && ack_op_q |=> acc_load_q && acc_data_q == $past(chk_data))
		else $error("read data not forwarded after check");
endmodule // lmref_sequencer
`default_nettype wire

// >>> tb/mem_array_model.sv
// storage array model: keeps written words and answers reads after a set delay
`timescale 1ns/1ns
`default_nettype none
module mem_array_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire lmref_pkg::arr_cmd_t arr_cmd,
	input wire logic [3:0] lat,
	input wire logic [21:0] flip,
	output logic [21:0] arr_rdata,
	output logic arr_rvalid
);
	import lmref_pkg::*;
	logic [WORD_W-1:0] mem [0:255];
	logic [4:0] cnt_q;
	logic [7:0] ra_q;
	// only the low address byte is kept, so tests stay inside 256 words
	initial for (int i = 0; i < 256; i++) mem[i] = '0;
	// flip corrupts answers only while a scenario sets it
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 5'h00;
			ra_q <= 8'h00;
			arr_rvalid <= 1'b0;
			arr_rdata <= 22'h2aaaaa;
		end else begin
			arr_rvalid <= 1'b0;
			arr_rdata <= ~arr_rdata; // idle bus toggles every cycle, so stale data never holds steady
			if (arr_cmd.we == 2'b11) mem[arr_cmd.addr[7:0]] <= arr_cmd.word;
			if (arr_cmd.rd) begin
				ra_q <= arr_cmd.addr[7:0];
				cnt_q <= {1'b0, lat} + 5'h01;
			end else if (cnt_q == 5'h01) begin
				arr_rvalid <= 1'b1;
				arr_rdata <= mem[ra_q] ^ flip;
				cnt_q <= 5'h00;
			end else if (cnt_q != 5'h00) begin
				cnt_q <= cnt_q - 5'h01;
			end
		end
	end
endmodule // mem_array_model
`default_nettype wire

// >>> tb/lmref_sequencer_test.sv
// testbench: reference sequencer against a storage array model
`timescale 1ns/1ns
`default_nettype none
module lmref_sequencer_test;
	import lmref_pkg::*;
	logic clock, rst_n, instr_valid, steer_to_index, branch_load, nip_take, io_req;
	logic [6:0] instr_opcode;
	logic [15:0] operand_data, accumulator_data, branch_addr;
	logic [3:0] reg_addr, lat;
	logic [31:0] reg_wdata, v;
	logic reg_write, reg_read;
	logic [21:0] flip, arr_rdata;
	logic arr_rvalid, ref_busy_q, release_acc_q, release_opnd_q, retire_write_q, retire_read_q;
	logic acc_load_q, load_index_q, nip_valid_q, io_ack_q;
	logic [15:0] acc_data_q, nip_q;
	arr_cmd_t arr_cmd_q;
	logic [31:0] reg_rdata_q;
	int fail_count, num_checks, cyc, io_acks;
	logic [15:0] pat [4] = '{16'h1234, 16'hbeef, 16'h0f0f, 16'hc3a5};

	lmref_sequencer lmref_sequencer_i (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
		.instr_opcode(instr_opcode), .steer_to_index(steer_to_index),
		.operand_data(operand_data), .accumulator_data(accumulator_data),
		.branch_load(branch_load), .branch_addr(branch_addr), .nip_take(nip_take),
		.io_req(io_req), .arr_rdata(arr_rdata), .arr_rvalid(arr_rvalid), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.ref_busy_q(ref_busy_q), .release_acc_q(release_acc_q), .release_opnd_q(release_opnd_q),
		.retire_write_q(retire_write_q), .retire_read_q(retire_read_q),
		.acc_load_q(acc_load_q), .load_index_q(load_index_q), .acc_data_q(acc_data_q),
		.nip_q(nip_q), .nip_valid_q(nip_valid_q), .io_ack_q(io_ack_q),
		.arr_cmd_q(arr_cmd_q), .reg_rdata_q(reg_rdata_q));
	mem_array_model mem_array_model_i (.clock(clock), .rst_n(rst_n), .arr_cmd(arr_cmd_q),
		.lat(lat), .flip(flip), .arr_rdata(arr_rdata), .arr_rvalid(arr_rvalid));

	// clock and hang guard; the ceiling is well above the few hundred cycles used
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (io_ack_q === 1'b1) io_acks++;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic complete_run();
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata_q;
	endtask
	// one operand reference; instr_valid pulsed one cycle, operand and accumulator held until the reference retires
	task automatic mem_ref(input logic wr, input logic [15:0] a, input logic [15:0] d,
		input logic ix);
		int n;
		logic ra, ro;
		ra = 1'b0;
		ro = 1'b0;
		for (n = 0; n < 300 && ref_busy_q !== 1'b0; n++) @(posedge clock) #1;
		@(posedge clock);
		instr_valid <= 1'b1;
		instr_opcode <= wr ? OPC_WRITE : OPC_READ;
		steer_to_index <= ix;
		operand_data <= a;
		accumulator_data <= d;
		@(posedge clock);
		instr_valid <= 1'b0;
		for (n = 0; n < 300; n++) begin
			#1;
			ra |= release_acc_q === 1'b1;
			ro |= release_opnd_q === 1'b1;
			if ((wr ? retire_write_q : acc_load_q) === 1'b1) break;
			@(posedge clock);
		end
		chk(ro, 1'b1);
		if (wr) begin
			chk(ra, 1'b1);
			repeat (2) @(posedge clock);
			#1;
			chk(arr_cmd_q.we, 2'b11);
			chk(arr_cmd_q.addr, a);
			chk(arr_cmd_q.word[15:0], d);
		end else begin
			chk(ra, 1'b0);
			chk(retire_read_q, 1'b1);
			chk(load_index_q, ix);
			chk(acc_data_q, d);
		end
	endtask

	// reset values, unmapped place, a write there leaves control unchanged
	task automatic regs_test();
		reg_rd(REG_CTRL, v);
		chk(v, 32'h1);
		reg_rd(4'h2, v);
		chk(v, 32'h0);
		reg_wr(4'h2, 32'hffffffff);
		reg_rd(REG_CTRL, v);
		chk(v, 32'h1);
		repeat (150) @(posedge clock);
		reg_rd(REG_STATUS, v);
		chk(v[0], 1'b0);
	endtask
	// parcels written by operand writes come back through the fetch path
	task automatic fetch_test();
		int n;
		for (int i = 0; i < 4; i++) mem_ref(1'b1, 16'h0040 + 16'(i), pat[i], 1'b0);
		@(posedge clock);
		branch_load <= 1'b1;
		branch_addr <= 16'h0040;
		@(posedge clock);
		branch_load <= 1'b0;
		reg_rd(REG_STATUS, v);
		chk(v[0], 1'b1);
		for (int i = 0; i < 4; i++) begin
			for (n = 0; n < 200 && nip_valid_q !== 1'b1; n++) @(posedge clock) #1;
			chk(nip_q, pat[i]);
			@(posedge clock);
			nip_take <= 1'b1;
			@(posedge clock);
			nip_take <= 1'b0;
			@(posedge clock) #1;
		end
	endtask
	// single error in data is corrected, double error in check bits is flagged
	task automatic err_test();
		reg_wr(REG_CTRL, 32'h0);
		repeat (40) @(posedge clock);
		reg_wr(REG_CTRL, 32'h2);
		@(posedge clock);
		flip <= 22'h000001;
		mem_ref(1'b0, 16'h0041, pat[1], 1'b0);
		@(posedge clock);
		flip <= 22'h300000;
		mem_ref(1'b0, 16'h0042, pat[2], 1'b0);
		@(posedge clock);
		flip <= 22'h0;
		reg_rd(REG_SEC_CNT, v);
		chk(v, 32'h1);
		reg_rd(REG_DED_CNT, v);
		chk(v, 32'h1);
		reg_rd(REG_STATUS, v);
		chk(v & 32'h3b, 32'h18);
	endtask
	// channel traffic alongside processor references, with a slow array answer
	task automatic io_test();
		@(posedge clock);
		io_req <= 1'b1;
		lat <= 4'h7;
		mem_ref(1'b1, 16'h0050, 16'h5a96, 1'b0);
		mem_ref(1'b0, 16'h0050, 16'h5a96, 1'b1);
		@(posedge clock);
		io_req <= 1'b0;
		lat <= 4'h0;
		chk(io_acks != 0, 1'b1);
	endtask

	initial begin
		rst_n = 1'b0;
		instr_valid = 1'b0;
		instr_opcode = 7'h00;
		steer_to_index = 1'b0;
		operand_data = 16'h0000;
		accumulator_data = 16'h0000;
		branch_load = 1'b0;
		branch_addr = 16'h0000;
		nip_take = 1'b0;
		io_req = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		lat = 4'h0;
		flip = 22'h0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		regs_test();
		fetch_test();
		err_test();
		io_test();
		complete_run();
	end
endmodule // lmref_sequencer_test
`default_nettype wire
